// [pkg/rt_modecode_map.vh]
/*
 * register offsets, field positions, reset values and decode constants
 * for the reset / reserved mode code handler.
 * assumes: included by bare name; definitions only.
 */
`ifndef RT_MODECODE_MAP_VH
`define RT_MODECODE_MAP_VH

// apb byte offsets
`define OFS_CONFIG 8'h00
`define OFS_ILLTBL 8'h04
`define OFS_STATUS 8'h08
`define OFS_BITWORD 8'h0C
`define OFS_DESC 8'h10
`define OFS_INFO 8'h14
`define OFS_IRQ_STAT 8'h18
`define OFS_IRQ_MASK 8'h1C

// config fields
`define CFG_UNDEFINED_MODECODE_INVALIDATE 0

// internal status word fields
`define ST_ME 0
`define ST_BUSY 1
`define ST_BCR 2
`define ST_TF_INH 3
`define ST_SHUT_A 4
`define ST_SHUT_B 5
`define ST_W 6
`define ST_HOST_MASK 6'h3A

// descriptor control word fields
`define DC_DATA_BLOCK_ACCESSED_FLAG 0
`define DC_BROADCAST_MSG_FLAG 1
`define DC_DPB 2
`define DC_W 3

// message info word fields
`define MI_RXBUS 0
`define MI_MSG_ERROR_INFO_FLAG 1
`define MI_ILLEGAL_CMD_FLAG 2
`define MI_RT_TO_RT_FLAG 3
`define MI_WORD_COUNT_ERROR_FLAG 4
`define MI_GAP_ERROR_FLAG 5
`define MI_W 6

// interrupt fields
`define IRQ_WA 0
`define IRQ_BR 1
`define IRQ_ILLEGAL_CMD_FLAG 2
`define IRQ_MSG_ERROR_INFO_FLAG 3
`define IRQ_W 4

// mode code decode
`define MC_RESET_RT 5'h08
`define MC_GROUP_HI 2'h1
`define BIT_CLEAR 16'h0000

// reset values
`define RST_CONFIG 1'h0
`define RST_ILLTBL 16'h0000
`define RST_STATUS 6'h00
`define RST_BITWORD 16'h0000

`endif

// [tb/bc_model.sv]
/* bus controller model: issues decoded mode commands, ends status words.
   assumes: caller enters send just after a rising edge. */
`timescale 1ns/10ps
module bc_model (
    input wire clk_i,
    input wire status_tx_i,
    output reg cmd_valid_o = 1'b0,
    output reg cmd_ok_o = 1'b0,
    output reg [4:0] code_o = 5'h00,
    output reg tr_o = 1'b0,
    output reg broadcast_msg_flag_o = 1'b0,
    output reg contig_o = 1'b0,
    output reg bus_b_o = 1'b0,
    output reg done_o = 1'b0
);
    int done_lag = 1;
    int cnt = 0;
    ////////////////////////////////////////////////////////////
    // status word leaves the wire done_lag cycles after the request
    always @(posedge clk_i)
    begin
        if (status_tx_i)
            cnt <= done_lag;
        else if (cnt != 0)
            cnt <= cnt - 1;
        done_o <= (cnt == 1);
    end
    // released qualifiers show inverse so stale values never pass
    task send(input logic ok, input logic [4:0] c, input logic t, b, g, u);
        begin
            @(posedge clk_i);
            {cmd_valid_o, cmd_ok_o, code_o, tr_o, broadcast_msg_flag_o, contig_o,
                bus_b_o} <= {1'b1, ok, c, t, b, g, u};
            @(posedge clk_i);
            cmd_valid_o <= 1'b0;
            {cmd_ok_o, code_o, tr_o, broadcast_msg_flag_o, contig_o, bus_b_o} <=
                ~{ok, c, t, b, g, u};
        end
    endtask
endmodule

// [tb/rt_modecode_props.sv]
/* port checker for the mode code handler.
   assumes: bound to the handler top, one clock domain. */
`timescale 1ns/10ps
`include "rt_modecode_map.vh"
module rt_modecode_props (
    input wire clk_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire cmd_valid_i,
    input wire cmd_word_ok_i,
    input wire [4:0] mode_code_i,
    input wire tr_bit_i,
    input wire broadcast_i,
    input wire contig_data_i,
    input wire pready_o,
    input wire status_tx_o,
    input wire info_wr_o,
    input wire tx_enable_a_o,
    input wire tx_enable_b_o,
    input wire tf_enable_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // valid command word inside this group
    wire grp = cmd_valid_i && cmd_word_ok_i &&
        mode_code_i[4:3] == `MC_GROUP_HI;
    sequence s_reset;
        grp && tr_bit_i && mode_code_i == `MC_RESET_RT;
    endsequence
    sequence s_resv;
        grp && tr_bit_i && mode_code_i != `MC_RESET_RT;
    endsequence
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    a_invalid_silent: assert property (
        cmd_valid_i && !cmd_word_ok_i |=> !status_tx_o && !info_wr_o)
        else $error("invalid command answered");
    a_reset_status: assert property (
        s_reset ##0 (!broadcast_i && !contig_data_i) |=> status_tx_o)
        else $error("reset command without status");
    a_broadcast_msg_flag_silent: assert property (
        grp && broadcast_i |=> !status_tx_o)
        else $error("status sent on broadcast");
    a_contig_silent: assert property (
        cmd_valid_i && contig_data_i |=> !status_tx_o)
        else $error("status sent after data word");
    a_reset_tx_on: assert property (
        s_reset ##0 !contig_data_i |=> tx_enable_a_o && tx_enable_b_o
        && tf_enable_o) else $error("shutdown or inhibit kept");
    a_resv_status: assert property (
        s_resv ##0 (!broadcast_i && !contig_data_i) |=> status_tx_o)
        else $error("reserved code without status");
    a_tr1_info: assert property (
        grp && tr_bit_i |=> info_wr_o)
        else $error("info word not written");
    a_apb_answer: assert property (
        s_setup |=> pready_o ##1 !pready_o)
        else $error("apb answer late or long");
endmodule
bind rt_reset_and_reserved_modecode_handler rt_modecode_props props_u (
    .clk_i, .rst_b_i, .psel_i, .penable_i, .cmd_valid_i, .cmd_word_ok_i,
    .mode_code_i, .tr_bit_i, .broadcast_i, .contig_data_i, .pready_o,
    .status_tx_o, .info_wr_o, .tx_enable_a_o, .tx_enable_b_o, .tf_enable_o);

// [tb/tb_top.sv]
/* self-checking bench for the mode code handler.
   assumes: handler, checker and bus controller model compiled before. */
`timescale 1ns/10ps
`include "rt_modecode_map.vh"
module tb_top;
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h00000000;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, cmd_valid_i, cmd_word_ok_i, tr_bit_i;
    wire broadcast_i, contig_data_i, bus_b_i, status_done_i, status_tx_o;
    wire info_wr_o, tx_enable_a_o, tx_enable_b_o, tf_enable_o, irq_o;
    wire [4:0] mode_code_i;
    int n_fail = 0, cmp_count = 0, seed = 32'hB9EA;
    logic [31:0] q;
    logic [15:0] tbl;
    logic err, t, tr, bus;
    always #12.5 clk_i = ~clk_i;
    rt_reset_and_reserved_modecode_handler dut_u (.clk_i, .rst_b_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .cmd_valid_i, .cmd_word_ok_i, .mode_code_i,
        .tr_bit_i, .broadcast_i, .contig_data_i, .bus_b_i, .status_done_i,
        .status_tx_o, .info_wr_o, .tx_enable_a_o, .tx_enable_b_o,
        .tf_enable_o, .irq_o);
    bc_model bc_u (.clk_i, .status_tx_i(status_tx_o),
        .cmd_valid_o(cmd_valid_i), .cmd_ok_o(cmd_word_ok_i),
        .code_o(mode_code_i), .tr_o(tr_bit_i), .broadcast_msg_flag_o(broadcast_i),
        .contig_o(contig_data_i), .bus_b_o(bus_b_i), .done_o(status_done_i));
    ////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d errors %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] e, g);
        begin
            cmp_count++;
            if (g !== e)
            begin
                n_fail++;
                $display("[ERR] %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
            @(posedge clk_i);
            penable_i <= 1'b1;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (pready_o !== 1'b1 && n < 20);
            q = prdata_o;
            err = pslverr_o;
            {psel_i, penable_i} <= 2'h0;
            if (n >= 20) chk("apb wait", 1, 0);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        begin
            apb(1'b0, a, 32'h00000000);
            chk(nm, e, q);
        end
    endtask
    // info word expected from table bit, direction and bus
    function logic [31:0] exp_info(input logic t, tr, b);
        exp_info = t ? {29'h0, 2'h3, b} : {31'h0, b & !tr};
    endfunction
    ////////////////////////////////////////////////////////////
    // hang guard, far beyond the planned run
    initial
    begin
        repeat (20000) @(posedge clk_i);
        chk("timeout", 1, 0);
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(`OFS_STATUS, 0, "status");
        apb(1'b0, 8'h40, 0);
        chk("unmapped", 1, err);
        wr(`OFS_STATUS, 32'h3A);
        wr(`OFS_BITWORD, 32'hA5C3);
        wr(`OFS_IRQ_MASK, 32'hF);
        wr(`OFS_CONFIG, 1);
        wr(`OFS_ILLTBL, 32'hFF);
        chk("tx a", 0, tx_enable_a_o);
        // bad word, then tr=0 under the invalidate option
        bc_u.send(1'b0, 5'h08, 1'b1, 1'b0, 1'b0, 1'b0);
        bc_u.send(1'b1, 5'h09, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(`OFS_DESC, 0, "desc");
        rd(`OFS_IRQ_STAT, 0, "irq st");
        // terminal reset with a slow status word
        bc_u.done_lag = 6;
        bc_u.send(1'b1, `MC_RESET_RT, 1'b1, 1'b0, 1'b0, 1'b1);
        // busy must survive until the slow status word has gone
        rd(`OFS_STATUS, 2, "status busy");
        repeat (12) @(posedge clk_i);
        rd(`OFS_STATUS, 0, "status");
        rd(`OFS_BITWORD, 0, "bit");
        rd(`OFS_CONFIG, 1, "config");
        rd(`OFS_ILLTBL, 32'hFF, "table");
        rd(`OFS_DESC, 4, "desc");
        rd(`OFS_INFO, 1, "info");
        rd(`OFS_IRQ_STAT, 1, "irq st");
        chk("irq", 1, irq_o);
        wr(`OFS_IRQ_STAT, 32'hF);
        wr(`OFS_CONFIG, 0);
        chk("irq", 0, irq_o);
        bc_u.done_lag = 1;
        // data word after the command word
        for (int k = 0; k < 2; k++)
        begin
            bc_u.send(1'b1, {4'h4, k[0]}, 1'b1, 1'b0, 1'b1, 1'b0);
            rd(`OFS_INFO, k ? 32'h12 : 32'h22, "info");
            rd(`OFS_STATUS, 1, "status");
            rd(`OFS_DESC, {29'h0, k[0], 2'h1}, "desc");
            rd(`OFS_IRQ_STAT, 32'h9, "irq st");
            wr(`OFS_IRQ_STAT, 32'hF);
        end
        // reserved tr=1 codes, then tr=0 broadcasts, random table
        for (int k = 9; k < 24; k++)
        begin
            tbl = 16'($random(seed));
            bus = 1'($random(seed));
            tr = (k < 16);
            t = tr ? tbl[k[2:0]] : tbl[8 + k[2:0]];
            wr(`OFS_ILLTBL, {16'h0, tbl});
            bc_u.send(1'b1, {2'h1, k[2:0]}, tr, !tr, 1'b0, bus);
            rd(`OFS_INFO, exp_info(t, tr, bus), "info");
            rd(`OFS_STATUS, {29'h0, !tr, 1'b0, t}, "status");
            rd(`OFS_IRQ_STAT, {29'h0, t, !tr, 1'b1}, "irq st");
            wr(`OFS_IRQ_STAT, 32'hF);
        end
        // host finishes the terminal reset with a master reset pulse
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(`OFS_ILLTBL, 0, "table");
        rd(`OFS_STATUS, 0, "status");
        end_sim();
    end
endmodule

// [verilog/rt_reset_and_reserved_modecode_handler.v]
/*
 * remote terminal handler for the reset remote terminal mode code and
 * the reserved mode codes 01001..01111, with an apb register file.
 * assumes: the bus front end presents one decoded command per cmd_valid_i
 * pulse with all qualifiers stable in that cycle, and pulses
 * status_done_i once the status word has left the transmitter.
 */
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "rt_modecode_map.vh"

module rt_reset_and_reserved_modecode_handler
(
    input wire clk_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire cmd_valid_i,
    input wire cmd_word_ok_i,
    input wire [4:0] mode_code_i,
    input wire tr_bit_i,
    input wire broadcast_i,
    input wire contig_data_i,
    input wire bus_b_i,
    input wire status_done_i,
    output wire status_tx_o,
    output wire info_wr_o,
    output wire tx_enable_a_o,
    output wire tx_enable_b_o,
    output wire tf_enable_o,
    output wire irq_o
);

////////////////////////////////////////////////////////////////////////
// state

reg [31:0] prdata_r;
reg pready_r;
reg pslverr_r;
reg cfg_undefined_modecode_invalidate_r;
reg [15:0] illtbl_r;
reg [`ST_W-1:0] status_r;
reg [15:0] bitword_r;
reg [`DC_W-1:0] desc_r;
reg [`MI_W-1:0] info_r;
reg [`IRQ_W-1:0] irq_stat_r;
reg [`IRQ_W-1:0] irq_mask_r;
reg reset_pend_r;
reg status_tx_r;
reg info_wr_r;
reg irq_r;

reg cfg_undefined_modecode_invalidate_nxt;
reg [15:0] illtbl_nxt;
reg [`ST_W-1:0] status_nxt;
reg [15:0] bitword_nxt;
reg [`DC_W-1:0] desc_nxt;
reg [`MI_W-1:0] info_nxt;
reg [`IRQ_W-1:0] irq_stat_nxt;
reg [`IRQ_W-1:0] irq_mask_nxt;
reg [`IRQ_W-1:0] irq_ev;
reg reset_pend_nxt;
reg status_tx_nxt;
reg info_wr_nxt;
reg [31:0] rdata_nxt;
reg rd_err;

////////////////////////////////////////////////////////////////////////
// decode helpers

// true when the offset names a mapped register
function is_mapped;
    input [7:0] a;
    begin
        is_mapped = (a == `OFS_CONFIG) || (a == `OFS_ILLTBL) ||
            (a == `OFS_STATUS) || (a == `OFS_BITWORD) ||
            (a == `OFS_DESC) || (a == `OFS_INFO) ||
            (a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK);
    end
endfunction

// table bit: low byte for tr=1, high byte for tr=0, index = code low 3
function tbl_bit;
    input [15:0] tbl;
    input tr;
    input [2:0] idx;
    begin
        tbl_bit = tbl[{~tr, idx}];
    end
endfunction

wire wr_en = psel_i & penable_i & pready_r & pwrite_i &
    is_mapped(paddr_i);
wire in_group = (mode_code_i[4:3] == `MC_GROUP_HI);
wire is_reset = (mode_code_i == `MC_RESET_RT);
wire table_hit = tbl_bit(illtbl_r, tr_bit_i, mode_code_i[2:0]);
// invalid word or tr=0 under the invalidate option: drop it silently
wire cmd_ignore = ~cmd_word_ok_i | (~tr_bit_i & cfg_undefined_modecode_invalidate_r);
wire cmd_take = cmd_valid_i & in_group & ~cmd_ignore;

////////////////////////////////////////////////////////////////////////
// apb read mux, answered in the setup cycle so access has no wait

always @*
begin
    rdata_nxt = 32'h00000000;
    rd_err = 1'b0;
    case (paddr_i)
        `OFS_CONFIG: rdata_nxt[0] = cfg_undefined_modecode_invalidate_r;
        `OFS_ILLTBL: rdata_nxt[15:0] = illtbl_r;
        `OFS_STATUS: rdata_nxt[`ST_W-1:0] = status_r;
        `OFS_BITWORD: rdata_nxt[15:0] = bitword_r;
        `OFS_DESC: rdata_nxt[`DC_W-1:0] = desc_r;
        `OFS_INFO: rdata_nxt[`MI_W-1:0] = info_r;
        `OFS_IRQ_STAT: rdata_nxt[`IRQ_W-1:0] = irq_stat_r;
        `OFS_IRQ_MASK: rdata_nxt[`IRQ_W-1:0] = irq_mask_r;
        default: rd_err = 1'b1;
    endcase
end

////////////////////////////////////////////////////////////////////////
// next state: host writes first, command effects override them

always @*
begin
    cfg_undefined_modecode_invalidate_nxt = cfg_undefined_modecode_invalidate_r;
    illtbl_nxt = illtbl_r;
    status_nxt = status_r;
    bitword_nxt = bitword_r;
    desc_nxt = desc_r;
    info_nxt = info_r;
    irq_mask_nxt = irq_mask_r;
    irq_ev = {`IRQ_W{1'b0}};
    reset_pend_nxt = reset_pend_r;
    status_tx_nxt = 1'b0;
    info_wr_nxt = 1'b0;

    // host side writes; me and bcr belong to the terminal
    if (wr_en)
    begin
        case (paddr_i)
            `OFS_CONFIG: cfg_undefined_modecode_invalidate_nxt = pwdata_i[`CFG_UNDEFINED_MODECODE_INVALIDATE];
            `OFS_ILLTBL: illtbl_nxt = pwdata_i[15:0];
            `OFS_STATUS: status_nxt = (status_r & ~`ST_HOST_MASK) |
                (pwdata_i[`ST_W-1:0] & `ST_HOST_MASK);
            `OFS_BITWORD: bitword_nxt = pwdata_i[15:0];
            `OFS_IRQ_MASK: irq_mask_nxt = pwdata_i[`IRQ_W-1:0];
            default: ;
        endcase
    end

    // status has left: drop me, busy and bcr after a reset command
    if (status_done_i & reset_pend_r)
    begin
        status_nxt[`ST_ME] = 1'b0;
        status_nxt[`ST_BUSY] = 1'b0;
        status_nxt[`ST_BCR] = 1'b0;
        reset_pend_nxt = 1'b0;
    end

    // every accepted command toggles dpb and writes the info word
    if (cmd_take)
    begin
        info_wr_nxt = 1'b1;
        desc_nxt[`DC_DPB] = ~desc_r[`DC_DPB];
        info_nxt = {`MI_W{1'b0}};
        info_nxt[`MI_RXBUS] = bus_b_i;
        irq_ev[`IRQ_WA] = 1'b1;
        if (contig_data_i)
        begin
            // trailing data word: error, never answered
            status_nxt[`ST_ME] = 1'b1;
            desc_nxt[`DC_DATA_BLOCK_ACCESSED_FLAG] = 1'b1;
            desc_nxt[`DC_BROADCAST_MSG_FLAG] = 1'b0;
            info_nxt[`MI_MSG_ERROR_INFO_FLAG] = 1'b1;
            info_nxt[`MI_GAP_ERROR_FLAG] = is_reset;
            info_nxt[`MI_WORD_COUNT_ERROR_FLAG] = ~is_reset;
            irq_ev[`IRQ_MSG_ERROR_INFO_FLAG] = 1'b1;
        end
        else if (~tr_bit_i)
        begin
            // tr=0 is undefined; table picks in form or illegal
            desc_nxt[`DC_DATA_BLOCK_ACCESSED_FLAG] = 1'b1;
            desc_nxt[`DC_BROADCAST_MSG_FLAG] = broadcast_i;
            status_nxt[`ST_ME] = table_hit;
            info_nxt[`MI_MSG_ERROR_INFO_FLAG] = table_hit;
            info_nxt[`MI_ILLEGAL_CMD_FLAG] = table_hit;
            irq_ev[`IRQ_ILLEGAL_CMD_FLAG] = table_hit;
            irq_ev[`IRQ_BR] = broadcast_i;
            if (broadcast_i)
                status_nxt[`ST_BCR] = 1'b1;
            else
                status_tx_nxt = 1'b1;
        end
        else if (is_reset)
        begin
            // reset remote terminal; configuration left as is
            status_nxt[`ST_ME] = 1'b0;
            desc_nxt[`DC_DATA_BLOCK_ACCESSED_FLAG] = 1'b0;
            desc_nxt[`DC_BROADCAST_MSG_FLAG] = broadcast_i;
            irq_ev[`IRQ_BR] = broadcast_i;
            bitword_nxt = `BIT_CLEAR;
            status_nxt[`ST_SHUT_A] = 1'b0;
            status_nxt[`ST_SHUT_B] = 1'b0;
            status_nxt[`ST_TF_INH] = 1'b0;
            if (broadcast_i)
            begin
                // no status goes out, so clear at once
                status_nxt[`ST_BUSY] = 1'b0;
                status_nxt[`ST_BCR] = 1'b1;
            end
            else
            begin
                status_tx_nxt = 1'b1;
                reset_pend_nxt = 1'b1;
            end
        end
        else
        begin
            // reserved tr=1 codes, response chosen by the table
            desc_nxt[`DC_DATA_BLOCK_ACCESSED_FLAG] = 1'b1;
            desc_nxt[`DC_BROADCAST_MSG_FLAG] = broadcast_i;
            status_nxt[`ST_ME] = table_hit;
            info_nxt[`MI_RXBUS] = table_hit & bus_b_i;
            info_nxt[`MI_MSG_ERROR_INFO_FLAG] = table_hit;
            info_nxt[`MI_ILLEGAL_CMD_FLAG] = table_hit;
            irq_ev[`IRQ_ILLEGAL_CMD_FLAG] = table_hit;
            if (broadcast_i)
                status_nxt[`ST_BCR] = 1'b1;
            else
                status_tx_nxt = 1'b1;
        end
    end

    // sticky events, write one to clear; a new event wins the clear
    irq_stat_nxt = irq_stat_r;
    if (wr_en && (paddr_i == `OFS_IRQ_STAT))
        irq_stat_nxt = irq_stat_r & ~pwdata_i[`IRQ_W-1:0];
    irq_stat_nxt = irq_stat_nxt | irq_ev;
end

////////////////////////////////////////////////////////////////////////
// registers

always @(posedge clk_i)
begin
    if (!rst_b_i)
    begin
        prdata_r <= 32'h00000000;
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        cfg_undefined_modecode_invalidate_r <= `RST_CONFIG;
        illtbl_r <= `RST_ILLTBL;
        status_r <= `RST_STATUS;
        bitword_r <= `RST_BITWORD;
        desc_r <= {`DC_W{1'b0}};
        info_r <= {`MI_W{1'b0}};
        irq_stat_r <= {`IRQ_W{1'b0}};
        irq_mask_r <= {`IRQ_W{1'b0}};
        reset_pend_r <= 1'b0;
        status_tx_r <= 1'b0;
        info_wr_r <= 1'b0;
        irq_r <= 1'b0;
    end
    else
    begin
        // ready rises for exactly the first access cycle
        pready_r <= psel_i & ~penable_i;
        pslverr_r <= psel_i & ~penable_i & rd_err;
        if (psel_i & ~penable_i)
            prdata_r <= pwrite_i ? 32'h00000000 : rdata_nxt;
        cfg_undefined_modecode_invalidate_r <= cfg_undefined_modecode_invalidate_nxt;
        illtbl_r <= illtbl_nxt;
        status_r <= status_nxt;
        bitword_r <= bitword_nxt;
        desc_r <= desc_nxt;
        info_r <= info_nxt;
        irq_stat_r <= irq_stat_nxt;
        irq_mask_r <= irq_mask_nxt;
        reset_pend_r <= reset_pend_nxt;
        status_tx_r <= status_tx_nxt;
        info_wr_r <= info_wr_nxt;
        // level output changes with status in the same cycle, a flop fed from the next state
        irq_r <= |(irq_stat_nxt & irq_mask_nxt);
    end
end

////////////////////////////////////////////////////////////////////////
// outputs, all from flops; the three enables are inverted status bits

assign prdata_o = prdata_r;
assign pready_o = pready_r;
assign pslverr_o = pslverr_r;
assign status_tx_o = status_tx_r;
assign info_wr_o = info_wr_r;
assign tx_enable_a_o = ~status_r[`ST_SHUT_A];
assign tx_enable_b_o = ~status_r[`ST_SHUT_B];
assign tf_enable_o = ~status_r[`ST_TF_INH];
assign irq_o = irq_r;

endmodule
